//--- logic/t2cr_pkg.sv
package t2cr_pkg;
	// Special-function addresses of the timer registers
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h8c;
	localparam logic [7:0] ADDR_CONTROL = 8'hc8;
	localparam logic [7:0] ADDR_CAPTURE_LOW = 8'hca;
	localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
	// Control bits are bit addresses c8..cf: upper five bits select the register
	localparam logic [4:0] CONTROL_BIT_PAGE = 5'h19;
	// Control field positions
	localparam int BIT_OVERFLOW = 7;
	localparam int BIT_EXTERNAL = 6;
	localparam int BIT_RX_BAUD = 5;
	localparam int BIT_TX_BAUD = 4;
	localparam int BIT_EXT_ENABLE = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_COUNTER = 1;
	localparam int BIT_CAPTURE = 0;
	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] CAPTURE_RESET = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// Trigger pin idles high, so a falling edge needs a high history
	localparam logic PIN_IDLE = 1'b1;
endpackage

//--- logic/t2cr_fall_detect.sv
`timescale 1ns/1ns
module t2cr_fall_detect
	import t2cr_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Pin level and edge
	input wire logic i_level,
	output logic o_fall
);
	logic prev_reg;
	logic prev_next;

	always_comb begin
		prev_next = i_level;
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prev_reg <= PIN_IDLE;
		end else begin
			prev_reg <= prev_next;
		end
	end

	assign o_fall = prev_reg & ~i_level;
endmodule

//--- logic/t2cr_timer.sv
`timescale 1ns/1ns
// Functional notes
// - Wrap from ffff (to 0000, or to the reload value) sets overflow flag
// - No overflow flag while any baud select
// - Overflow flag requests interrupt; software clears only
// - Pin-triggered capture/reload sets external flag
// - Receive baud select drives receiver baud clock
// - Transmit baud select drives transmitter baud clock
// - External enable lets pin falling edge trigger, except in baud
// - Counter advances only while run bit set
// - Counter select: pin events, else clock periods
// - Capture select: capture on each pin fall
// - Reload select: reload on overflow and pin
// - Capture select needs external enable, ignored in baud
// - Capture halves at ca/cb, count high cd
module t2cr_timer
	import t2cr_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Byte access from the core
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_write,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// Single-bit access from the core
	input wire logic [7:0] i_bit_addr,
	input wire logic i_bit_write,
	input wire logic i_bit_wdata,
	output logic o_bit_rdata,
	// External trigger pin
	input wire logic i_external_trigger_pin,
	// Interrupt request and baud clocks
	output logic o_timer_request,
	output logic o_rx_baud_tick,
	output logic o_tx_baud_tick
);
	logic [7:0] control_reg, control_next;
	logic [WIDTH-1:0] count_reg, count_next;
	logic [WIDTH-1:0] capture_reg, capture_next;
	logic [7:0] rdata_reg, rdata_next;
	logic bit_rdata_reg, bit_rdata_next;
	logic rx_tick_reg, rx_tick_next;
	logic tx_tick_reg, tx_tick_next;
	logic pin_fall;
	logic baud_mode, step, wrap, pin_trigger, do_capture, do_reload, capture_mode;
	logic ctrl_byte_write, ctrl_bit_write;
	logic [7:0] ctrl_sw;

	t2cr_fall_detect u_fall (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_level(i_external_trigger_pin),
		.o_fall(pin_fall)
	);

	// Event decode
	always_comb begin
		baud_mode = control_reg[BIT_RX_BAUD] | control_reg[BIT_TX_BAUD];
		// Counter mode steps on pin falls, timer mode on every clock
		step = control_reg[BIT_RUN] & (control_reg[BIT_COUNTER] ? pin_fall : 1'b1);
		wrap = step && (count_reg == {WIDTH{1'b1}});
		// Capture select is honoured only with external enable, never in baud mode
		capture_mode = control_reg[BIT_CAPTURE] & control_reg[BIT_EXT_ENABLE] & ~baud_mode;
		pin_trigger = control_reg[BIT_EXT_ENABLE] & pin_fall & ~baud_mode;
		do_capture = pin_trigger & capture_mode;
		// Baud generation always auto-reloads so the rate is set by the pair
		do_reload = (wrap & ~capture_mode) | (pin_trigger & ~capture_mode);
		ctrl_byte_write = i_sfr_write && (i_sfr_addr == ADDR_CONTROL);
		ctrl_bit_write = i_bit_write && (i_bit_addr[7:3] == CONTROL_BIT_PAGE);
	end

	// Control register: software value, then hardware sets win over clears
	always_comb begin
		ctrl_sw = control_reg;
		if (ctrl_byte_write) begin
			ctrl_sw = i_sfr_wdata;
		end else if (ctrl_bit_write) begin
			ctrl_sw[i_bit_addr[2:0]] = i_bit_wdata;
		end
		control_next = ctrl_sw;
		if (wrap && !baud_mode) begin
			control_next[BIT_OVERFLOW] = 1'b1;
		end
		if (pin_trigger) begin
			control_next[BIT_EXTERNAL] = 1'b1;
		end
	end

	// Count and capture pair
	always_comb begin
		count_next = count_reg;
		capture_next = capture_reg;
		if (do_reload) begin
			count_next = capture_reg;
		end else if (step) begin
			count_next = count_reg + COUNT_ONE;
		end
		// Software writes beat hardware on the count; the core owns it then
		if (i_sfr_write && i_sfr_addr == ADDR_COUNT_LOW) begin
			count_next[7:0] = i_sfr_wdata;
		end
		if (i_sfr_write && i_sfr_addr == ADDR_COUNT_HIGH) begin
			count_next[15:8] = i_sfr_wdata;
		end
		if (i_sfr_write && i_sfr_addr == ADDR_CAPTURE_LOW) begin
			capture_next[7:0] = i_sfr_wdata;
		end
		if (i_sfr_write && i_sfr_addr == ADDR_CAPTURE_HIGH) begin
			capture_next[15:8] = i_sfr_wdata;
		end
		// A captured count must not be lost to a racing write
		if (do_capture) begin
			capture_next = count_reg;
		end
	end

	// Read data and baud ticks, registered
	always_comb begin
		unique case (i_sfr_addr)
			ADDR_COUNT_LOW: rdata_next = count_reg[7:0];
			ADDR_COUNT_HIGH: rdata_next = count_reg[15:8];
			ADDR_CAPTURE_LOW: rdata_next = capture_reg[7:0];
			ADDR_CAPTURE_HIGH: rdata_next = capture_reg[15:8];
			ADDR_CONTROL: rdata_next = control_reg;
			default: rdata_next = READ_UNMAPPED;
		endcase
		bit_rdata_next = (i_bit_addr[7:3] == CONTROL_BIT_PAGE) ? control_reg[i_bit_addr[2:0]] : 1'b0;
		rx_tick_next = wrap & control_reg[BIT_RX_BAUD];
		tx_tick_next = wrap & control_reg[BIT_TX_BAUD];
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			control_reg <= CONTROL_RESET;
			count_reg <= COUNT_RESET;
			capture_reg <= CAPTURE_RESET;
			rdata_reg <= READ_UNMAPPED;
			bit_rdata_reg <= 1'b0;
			rx_tick_reg <= 1'b0;
			tx_tick_reg <= 1'b0;
		end else begin
			control_reg <= control_next;
			count_reg <= count_next;
			capture_reg <= capture_next;
			rdata_reg <= rdata_next;
			bit_rdata_reg <= bit_rdata_next;
			rx_tick_reg <= rx_tick_next;
			tx_tick_reg <= tx_tick_next;
		end
	end

	assign o_sfr_rdata = rdata_reg;
	assign o_bit_rdata = bit_rdata_reg;
	// Enable and priority live in the interrupt controller
	assign o_timer_request = control_reg[BIT_OVERFLOW] | control_reg[BIT_EXTERNAL];
	assign o_rx_baud_tick = rx_tick_reg;
	assign o_tx_baud_tick = tx_tick_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	logic no_ctrl_write;
	logic no_count_write;
	assign no_ctrl_write = !ctrl_byte_write && !ctrl_bit_write;
	assign no_count_write = !(i_sfr_write &&
		(i_sfr_addr == ADDR_COUNT_LOW || i_sfr_addr == ADDR_COUNT_HIGH));

	sequence s_wrap_normal;
		control_reg[BIT_RUN] && !baud_mode && count_reg == {WIDTH{1'b1}} && step;
	endsequence

	property p_overflow_set;
		s_wrap_normal |=> control_reg[BIT_OVERFLOW];
	endproperty
	a_overflow_set: assert property (p_overflow_set) else $error("overflow flag not set");

	property p_no_overflow_baud;
		baud_mode && !control_reg[BIT_OVERFLOW] && no_ctrl_write |=> !control_reg[BIT_OVERFLOW];
	endproperty
	a_no_overflow_baud: assert property (p_no_overflow_baud) else $error("flag set in baud");

	property p_flag_sticky;
		control_reg[BIT_OVERFLOW] && no_ctrl_write |=> control_reg[BIT_OVERFLOW] && o_timer_request;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag lost");

	property p_external_flag;
		control_reg[BIT_EXT_ENABLE] && !baud_mode && pin_fall |=> control_reg[BIT_EXTERNAL];
	endproperty
	a_external_flag: assert property (p_external_flag) else $error("external flag missing");

	property p_rx_tick;
		wrap && control_reg[BIT_RX_BAUD] |=> o_rx_baud_tick ##1 !o_rx_baud_tick || $past(wrap);
	endproperty
	a_rx_tick: assert property (p_rx_tick) else $error("receive tick wrong");

	property p_tx_tick;
		o_tx_baud_tick |-> $past(wrap) && $past(control_reg[BIT_TX_BAUD]);
	endproperty
	a_tx_tick: assert property (p_tx_tick) else $error("transmit tick spurious");

	property p_hold_stopped;
		!control_reg[BIT_RUN] && !pin_trigger && no_count_write |=> $stable(count_reg);
	endproperty
	a_hold_stopped: assert property (p_hold_stopped) else $error("count moved while stopped");

	property p_capture;
		do_capture |=> capture_reg == $past(count_reg);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	property p_reload;
		s_wrap_normal ##0 !capture_mode && no_count_write |=> count_reg == $past(capture_reg);
	endproperty
	a_reload: assert property (p_reload) else $error("reload value wrong");

	property p_baud_ignores_pin;
		baud_mode && pin_fall && !control_reg[BIT_EXTERNAL] && no_ctrl_write |=>
			!control_reg[BIT_EXTERNAL];
	endproperty
	a_baud_ignores_pin: assert property (p_baud_ignores_pin) else $error("pin acted in baud");
endmodule

//--- testbench/t2cr_partner.sv
`timescale 1ns/1ns
module t2cr_partner
	import t2cr_pkg::*;
(
	// Clock, reset and request
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_fall_req,
	// Timer side
	input wire logic i_rx_baud_tick,
	input wire logic i_tx_baud_tick,
	output logic o_pin,
	output logic [7:0] o_rx_count,
	output logic [7:0] o_tx_count
);
	// Pin is pulled up; held low one cycle per request so each fall has a high history
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pin <= PIN_IDLE;
			o_rx_count <= 8'h00;
			o_tx_count <= 8'h00;
		end else begin
			o_pin <= !i_fall_req;
			o_rx_count <= o_rx_count + {7'h00, i_rx_baud_tick};
			o_tx_count <= o_tx_count + {7'h00, i_tx_baud_tick};
		end
	end
endmodule

//--- testbench/test_timer2_capture_reload.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_timer2_capture_reload
	import t2cr_pkg::*;
;
	logic i_clock, i_reset_n, i_sfr_write, i_bit_write, i_bit_wdata, pin, req, fall_req;
	logic rx_tick, tx_tick, o_bit_rdata;
	logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_bit_addr, d, rx_n, tx_n;
	int n_fail = 0;
	int n_compared = 0;
	// Address, write data, expected read
	logic [23:0] rows [5] = '{24'hcd1212, 24'h8c3434, 24'hca0000, 24'hcbffff, 24'hc95500};
	t2cr_timer t2cr_timer_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_sfr_addr(i_sfr_addr), .i_sfr_write(i_sfr_write), .i_sfr_wdata(i_sfr_wdata),
		.o_sfr_rdata(o_sfr_rdata), .i_bit_addr(i_bit_addr), .i_bit_write(i_bit_write),
		.i_bit_wdata(i_bit_wdata), .o_bit_rdata(o_bit_rdata), .i_external_trigger_pin(pin),
		.o_timer_request(req), .o_rx_baud_tick(rx_tick), .o_tx_baud_tick(tx_tick));
	t2cr_partner t2cr_partner_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_fall_req(fall_req), .i_rx_baud_tick(rx_tick), .i_tx_baud_tick(tx_tick),
		.o_pin(pin), .o_rx_count(rx_n), .o_tx_count(tx_n));
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = !i_clock;
	end
	task automatic conclude();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// All tasks start and end just after a falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		i_sfr_addr = a;
		i_sfr_wdata = v;
		i_sfr_write = 1'b1;
		@(negedge i_clock);
		i_sfr_write = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		i_sfr_addr = a;
		@(negedge i_clock);
		d = o_sfr_rdata;
	endtask
	task automatic bw(input logic [7:0] a, input logic v);
		i_bit_addr = a;
		i_bit_wdata = v;
		i_bit_write = 1'b1;
		@(negedge i_clock);
		i_bit_write = 1'b0;
	endtask
	task automatic fall();
		fall_req = 1'b1;
		@(negedge i_clock);
		fall_req = 1'b0;
		repeat (3) @(negedge i_clock);
	endtask
	task automatic wait_req(input int lim);
		for (int k = 0; k < lim && req !== 1'b1; k++) begin
			@(negedge i_clock);
		end
		if (req !== 1'b1) begin
			n_fail++;
			$display("BAD request wait exp 1 got %b", req);
			conclude();
		end
	endtask
	initial begin
		{i_reset_n, i_sfr_write, i_bit_write, i_bit_wdata, fall_req} = 5'h00;
		{i_sfr_addr, i_sfr_wdata, i_bit_addr} = 24'h000000;
		repeat (4) @(negedge i_clock);
		i_reset_n = 1'b1;
		rd(ADDR_CONTROL);
		`CHK("control reset", CONTROL_RESET, d)
		foreach (rows[k]) begin
			wr(rows[k][23:16], rows[k][15:8]);
			rd(rows[k][23:16]);
			`CHK("sfr readback", rows[k][7:0], d)
		end
		// Wrap with reload pair ff00 so the high byte stays ff afterwards
		wr(ADDR_COUNT_LOW, 8'hfd);
		wr(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_CONTROL, 8'h04);
		wait_req(10);
		repeat (3) @(negedge i_clock);
		`CHK("flag held", 1'b1, req)
		wr(ADDR_CONTROL, 8'h00);
		`CHK("flag cleared", 1'b0, req)
		rd(ADDR_COUNT_HIGH);
		`CHK("reload high", 8'hff, d)
		wr(ADDR_COUNT_LOW, 8'h10);
		repeat (5) @(negedge i_clock);
		rd(ADDR_COUNT_LOW);
		`CHK("held count", 8'h10, d)
		wr(ADDR_COUNT_HIGH, 8'h12);
		wr(ADDR_COUNT_LOW, 8'h34);
		wr(ADDR_CONTROL, 8'h09);
		fall();
		rd(ADDR_CAPTURE_LOW);
		`CHK("capture low", 8'h34, d)
		rd(ADDR_CAPTURE_HIGH);
		`CHK("capture high", 8'h12, d)
		i_bit_addr = 8'hce;
		@(negedge i_clock);
		`CHK("external flag", 1'b1, o_bit_rdata)
		bw(8'hce, 1'b0);
		`CHK("bit clear", 1'b0, req)
		wr(ADDR_CONTROL, 8'h08);
		wr(ADDR_COUNT_HIGH, 8'h00);
		fall();
		rd(ADDR_COUNT_HIGH);
		`CHK("pin reload", 8'h12, d)
		wr(ADDR_CONTROL, 8'h06);
		wr(ADDR_COUNT_LOW, 8'h00);
		repeat (3) fall();
		wr(ADDR_CONTROL, 8'h00);
		rd(ADDR_COUNT_LOW);
		`CHK("event count", 8'h03, d)
		wr(ADDR_CAPTURE_LOW, 8'hf0);
		wr(ADDR_CAPTURE_HIGH, 8'hff);
		wr(ADDR_COUNT_HIGH, 8'hff);
		// Start at fffc: wraps 4, 20 and 36 cycles after run, stopped before the fourth
		wr(ADDR_COUNT_LOW, 8'hfc);
		wr(ADDR_CONTROL, 8'h3d);
		fall();
		repeat (40) @(negedge i_clock);
		// Checked before the control write, which would clear any flag
		`CHK("no flags in baud", 1'b0, req)
		wr(ADDR_CONTROL, 8'h30);
		rd(ADDR_COUNT_HIGH);
		`CHK("baud reload", 8'hff, d)
		rd(ADDR_COUNT_LOW);
		`CHK("baud count low", 8'hf9, d)
		`CHK("rx ticks", 8'h03, rx_n)
		`CHK("tx ticks", 8'h03, tx_n)
		// Reset with run cleared and baud selects still set must bring every register back
		i_reset_n = 1'b0;
		@(negedge i_clock);
		i_reset_n = 1'b1;
		rd(ADDR_CONTROL);
		`CHK("control after reset", CONTROL_RESET, d)
		rd(ADDR_COUNT_HIGH);
		`CHK("count after reset", COUNT_RESET[15:8], d)
		rd(ADDR_CAPTURE_LOW);
		`CHK("capture after reset", CAPTURE_RESET[7:0], d)
		`CHK("request after reset", 1'b0, req)
		conclude();
	end
endmodule
